// ==== design/fsol_map.vh ====
// Register map, field positions and encodings for the flash security option loader
`ifndef FSOL_MAP_VH
`define FSOL_MAP_VH
// -----------------------------------------------------------------------------
// Addresses
// -----------------------------------------------------------------------------
`define FSOL_HIGH_PAGE_BASE 16'h1800
`define FSOL_HIGH_PAGE_LAST 16'h185f
`define FSOL_ADDR_OPTION 16'h1821
`define FSOL_ADDR_CONFIG 16'h1823
`define FSOL_ADDR_PROTECT 16'h1824
`define FSOL_NV_KEY_BASE 16'hffb0
`define FSOL_NV_KEY_LAST 16'hffb7
`define FSOL_NV_PROTECT 16'hffbd
`define FSOL_NV_OPTION 16'hffbf
// -----------------------------------------------------------------------------
// Fields
// -----------------------------------------------------------------------------
`define FSOL_OPT_KEY_ENABLE_BIT 7
`define FSOL_OPT_NORED_BIT 6
`define FSOL_OPT_LOCK_MSB 1
`define FSOL_OPT_LOCK_LSB 0
`define FSOL_LOCK_OPEN 2'h2
`define FSOL_LOCK_FORCE 2'h3
`define FSOL_OPT_RSVD_MASK 8'hc3
`define FSOL_CFG_KEY_ACCESS_BIT 5
`define FSOL_CFG_MASK 8'h20
`define FSOL_KEY_BYTES 4'h8
`define FSOL_KEY_IDX_LAST 3'h7
`define FSOL_ZERO_BYTE 8'h00
`define FSOL_ERASED_BYTE 8'hff
`endif

// ==== design/fsol_key_compare.v ====
// Backdoor key byte comparator collecting an 8-byte match
module fsol_key_compare #(
    parameter NBYTES = 8
) (
    // Clock and reset
    input wire MCLK,
    input wire RESETN,
    // Control
    input wire clear,
    input wire byte_valid,
    input wire [2:0] byte_index,
    input wire [7:0] byte_data,
    input wire [8*NBYTES-1:0] key,
    // Result
    output reg all_match
);
    reg [NBYTES-1:0] hit_reg;
    reg [NBYTES-1:0] hit_next;
    integer i;

    always @* begin
        hit_next = hit_reg;
        if (clear) begin
            hit_next = {NBYTES{1'b0}};
        end else if (byte_valid) begin
            for (i = 0; i < NBYTES; i = i + 1) begin
                if (byte_index == i[2:0]) begin
                    hit_next[i] = (key[8*i +: 8] == byte_data);
                end
            end
        end
    end

    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            hit_reg <= {NBYTES{1'b0}};
            all_match <= 1'b0;
        end else begin
            hit_reg <= hit_next;
            all_match <= &hit_next;
        end
    end
endmodule // fsol_key_compare

// ==== design/fsol_loader.v ====
// Protection and option loader with security gating of RAM
`include "fsol_map.vh"

module fsol_loader (
    // Clock and reset
    input wire MCLK,
    input wire RESETN,
    // CPU bus
    input wire [15:0] BUS_ADDR,
    input wire [7:0] BUS_WDATA,
    input wire BUS_WR,
    input wire BUS_RD,
    input wire BUS_FROM_SECURE,
    input wire BUS_DEBUG,
    output reg [7:0] BUS_RDATA,
    output wire BUS_HIT,
    // Nonvolatile read port
    output wire [15:0] NV_ADDR,
    input wire [7:0] NV_DATA,
    // Flash engine status
    input wire BLANK_AFTER_ERASE,
    // RAM access gate
    input wire RAM_SEL,
    output wire RAM_DENY,
    // Live state
    output wire [7:0] LIVE_PROTECT,
    output wire [7:0] LIVE_OPTION,
    output wire SECURED,
    output wire LOAD_DONE
);
    // -------------------------------------------------------------------------
    // Load sequencer
    // -------------------------------------------------------------------------
    localparam ST_KEY = 2'h0;
    localparam ST_PROT = 2'h1;
    localparam ST_OPT = 2'h2;
    localparam ST_RUN = 2'h3;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [2:0] kidx_reg;
    reg [2:0] kidx_next;
    reg [63:0] key_reg;
    reg [63:0] key_next;
    reg [7:0] prot_reg;
    reg [7:0] prot_next;
    reg [7:0] opt_reg;
    reg [7:0] opt_next;
    reg [7:0] cfg_reg;
    reg [7:0] cfg_next;
    reg unlock_reg;
    reg unlock_next;
    reg [2:0] widx_reg;
    reg [2:0] widx_next;
    reg prot_wr_reg;
    reg prot_wr_next;

    // -------------------------------------------------------------------------
    // Address and security decode
    // -------------------------------------------------------------------------
    wire run = (state_reg == ST_RUN);
    wire lock_open = (opt_reg[`FSOL_OPT_LOCK_MSB:`FSOL_OPT_LOCK_LSB] == `FSOL_LOCK_OPEN);
    wire key_en = opt_reg[`FSOL_OPT_KEY_ENABLE_BIT];
    wire key_access = cfg_reg[`FSOL_CFG_KEY_ACCESS_BIT];
    wire in_page = (BUS_ADDR >= `FSOL_HIGH_PAGE_BASE) && (BUS_ADDR <= `FSOL_HIGH_PAGE_LAST);
    wire hit_opt = in_page && (BUS_ADDR == `FSOL_ADDR_OPTION);
    wire hit_cfg = in_page && (BUS_ADDR == `FSOL_ADDR_CONFIG);
    wire hit_prot = in_page && (BUS_ADDR == `FSOL_ADDR_PROTECT);
    // Key bytes are written into the key's own address range
    wire key_window = (BUS_ADDR >= `FSOL_NV_KEY_BASE) && (BUS_ADDR <= `FSOL_NV_KEY_LAST);
    // Arming the access bit restarts the byte count and the compare
    wire cfg_write = BUS_WR && hit_cfg;
    // Key bytes only count from secure code, never from debug
    wire key_ok_src = BUS_FROM_SECURE && !BUS_DEBUG;
    wire key_write = run && key_en && key_access && key_ok_src && BUS_WR && key_window;
    wire match;

    // -------------------------------------------------------------------------
    // Security state and live outputs
    // -------------------------------------------------------------------------
    assign SECURED = !(lock_open || unlock_reg);
    // Deny only gates an access; RAM contents are never touched here
    assign RAM_DENY = SECURED && RAM_SEL && (BUS_DEBUG || !BUS_FROM_SECURE);
    assign BUS_HIT = hit_opt || hit_cfg || hit_prot;
    assign LIVE_PROTECT = prot_reg;
    assign LIVE_OPTION = opt_reg;
    assign LOAD_DONE = run;
    // Nonvolatile address walks the key bytes, then protect, then option
    assign NV_ADDR = (state_reg == ST_KEY) ? (`FSOL_NV_KEY_BASE + {13'h0000, kidx_reg}) :
                     (state_reg == ST_PROT) ? `FSOL_NV_PROTECT : `FSOL_NV_OPTION;

    // -------------------------------------------------------------------------
    // Backdoor key comparator
    // -------------------------------------------------------------------------
    fsol_key_compare #(
        .NBYTES(8)
    ) u_cmp (
        .MCLK(MCLK),
        .RESETN(RESETN),
        .clear(!key_access || cfg_write),
        .byte_valid(key_write),
        .byte_index(widx_reg),
        .byte_data(BUS_WDATA),
        .key(key_reg),
        .all_match(match)
    );

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        kidx_next = kidx_reg;
        key_next = key_reg;
        prot_next = prot_reg;
        opt_next = opt_reg;
        cfg_next = cfg_reg;
        unlock_next = unlock_reg;
        widx_next = widx_reg;
        prot_wr_next = prot_wr_reg;
        case (state_reg)
            ST_KEY: begin
                // Byte index wraps to zero as the protect fetch begins
                key_next[8*kidx_reg +: 8] = NV_DATA;
                kidx_next = kidx_reg + 3'h1;
                if (kidx_reg == `FSOL_KEY_IDX_LAST) begin
                    state_next = ST_PROT;
                end
            end
            ST_PROT: begin
                prot_next = NV_DATA;
                state_next = ST_OPT;
            end
            ST_OPT: begin
                // Reserved option bits always read as zero
                opt_next = NV_DATA & `FSOL_OPT_RSVD_MASK;
                state_next = ST_RUN;
            end
            ST_RUN: begin
                if (cfg_write) begin
                    cfg_next = BUS_WDATA & `FSOL_CFG_MASK;
                    widx_next = 3'h0;
                end
                // Protect may be overwritten with any value once per reset by a bus write
                if (BUS_WR && hit_prot && !prot_wr_reg) begin
                    prot_next = BUS_WDATA;
                    prot_wr_next = 1'b1;
                end
                if (key_write) begin
                    widx_next = widx_reg + 3'h1;
                end
                // A match only opens the part while the key is enabled
                if (match && key_en) begin
                    unlock_next = 1'b1;
                end
                // Erase then blank verify opens the part
                if (BLANK_AFTER_ERASE) begin
                    unlock_next = 1'b1;
                end
            end
            default: begin
                state_next = ST_KEY;
            end
        endcase
    end

    // -------------------------------------------------------------------------
    // Register update
    // -------------------------------------------------------------------------
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= ST_KEY;
            kidx_reg <= 3'h0;
            key_reg <= {8{`FSOL_ERASED_BYTE}};
            prot_reg <= `FSOL_ERASED_BYTE;
            // Secured until the stored option byte has been read
            opt_reg <= {6'h00, `FSOL_LOCK_FORCE};
            cfg_reg <= `FSOL_ZERO_BYTE;
            unlock_reg <= 1'b0;
            widx_reg <= 3'h0;
            prot_wr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            kidx_reg <= kidx_next;
            key_reg <= key_next;
            prot_reg <= prot_next;
            opt_reg <= opt_next;
            cfg_reg <= cfg_next;
            unlock_reg <= unlock_next;
            widx_reg <= widx_next;
            prot_wr_reg <= prot_wr_next;
        end
    end

    // -------------------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------------------
    // Unmapped reads return zero so no stale byte leaks out
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            BUS_RDATA <= `FSOL_ZERO_BYTE;
        end else if (BUS_RD && hit_opt) begin
            BUS_RDATA <= opt_reg;
        end else if (BUS_RD && hit_cfg) begin
            BUS_RDATA <= cfg_reg;
        end else if (BUS_RD && hit_prot) begin
            BUS_RDATA <= prot_reg;
        end else begin
            BUS_RDATA <= `FSOL_ZERO_BYTE;
        end
    end
endmodule // fsol_loader

// ==== testbench/fsol_loader_props.sv ====
// Concurrent checks on the loader's ports
module fsol_loader_props (
    // Clock and reset
    input logic MCLK,
    input logic RESETN,
    // Bus and RAM gate
    input logic [15:0] BUS_ADDR,
    input logic BUS_RD,
    input logic BUS_DEBUG,
    input logic [7:0] BUS_RDATA,
    input logic BUS_HIT,
    input logic RAM_SEL,
    input logic RAM_DENY,
    // Load and security state
    input logic [15:0] NV_ADDR,
    input logic [7:0] LIVE_OPTION,
    input logic SECURED,
    input logic LOAD_DONE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    sequence s_stored_fetch;
        NV_ADDR == 16'hffbd ##1 NV_ADDR == 16'hffbf;
    endsequence
    AST_LOAD_ORDER: assert property (s_stored_fetch |=> LOAD_DONE)
        else $error("load not done after stored bytes");
    AST_LOCK_CODE: assert property (LOAD_DONE && !$past(LOAD_DONE) |-> SECURED == (LIVE_OPTION[1:0] != 2'h2))
        else $error("lock state decode wrong");
    AST_DEBUG_DENY: assert property (SECURED && RAM_SEL && BUS_DEBUG |-> RAM_DENY)
        else $error("debug reached secured RAM");
    AST_OPEN_RAM: assert property (!SECURED && RAM_SEL |-> !RAM_DENY)
        else $error("RAM denied while open");
    AST_HIT: assert property (BUS_HIT == (BUS_ADDR == 16'h1821 || BUS_ADDR == 16'h1823 || BUS_ADDR == 16'h1824))
        else $error("register decode wrong");
    AST_MISS_ZERO: assert property (BUS_RD && !BUS_HIT |=> BUS_RDATA == 8'h00)
        else $error("unmapped read not zero");
    AST_HOLD: assert property (LOAD_DONE && $past(LOAD_DONE) |-> $stable(LIVE_OPTION[7:2]))
        else $error("live option changed");
    AST_NO_RELOCK: assert property (LOAD_DONE && $past(LOAD_DONE) |-> !$rose(SECURED))
        else $error("security reengaged without reset");
    AST_LOAD_SECURED: assert property (!LOAD_DONE |-> SECURED)
        else $error("part open before load finished");
    AST_RAM_IDLE: assert property (!RAM_SEL |-> !RAM_DENY)
        else $error("deny raised without RAM access");
endmodule // fsol_loader_props

// ==== testbench/fsol_nv_model.sv ====
// Nonvolatile area model answering the loader's read port
module fsol_nv_model #(
    parameter logic [63:0] KEY = 64'h0,
    parameter logic [7:0] PROT = 8'hff
) (
    // Read port
    input logic [15:0] nv_addr,
    output logic [7:0] nv_data,
    // Stored option byte
    input logic [7:0] opt_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        nv_data = 8'hff;
        if (nv_addr >= 16'hffb0 && nv_addr <= 16'hffb7) begin
            nv_data = KEY[8*nv_addr[2:0] +: 8];
        end
        if (nv_addr == 16'hffbd) begin
            nv_data = PROT;
        end
        if (nv_addr == 16'hffbf) begin
            nv_data = opt_byte;
        end
    end
endmodule // fsol_nv_model

// ==== testbench/flash_security_option_loader_tb_top.sv ====
// Bench for the flash security option loader
module flash_security_option_loader_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] KEY = 64'h0123456789abcdef;
    logic MCLK = 0, RESETN = 0, BUS_WR = 0, BUS_RD = 0, BUS_FROM_SECURE = 1, BUS_DEBUG = 0;
    logic BLANK_AFTER_ERASE = 0, RAM_SEL = 0, BUS_HIT, RAM_DENY, SECURED, LOAD_DONE;
    logic [15:0] BUS_ADDR = 0, NV_ADDR;
    logic [7:0] BUS_WDATA = 0, opt_byte = 0, BUS_RDATA, NV_DATA, LIVE_PROTECT, LIVE_OPTION;
    int fail_count = 0, num_checks = 0;
    fsol_loader uut (.MCLK(MCLK), .RESETN(RESETN), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_WR(BUS_WR),
        .BUS_RD(BUS_RD), .BUS_FROM_SECURE(BUS_FROM_SECURE), .BUS_DEBUG(BUS_DEBUG), .BUS_RDATA(BUS_RDATA),
        .BUS_HIT(BUS_HIT), .NV_ADDR(NV_ADDR), .NV_DATA(NV_DATA), .BLANK_AFTER_ERASE(BLANK_AFTER_ERASE),
        .RAM_SEL(RAM_SEL), .RAM_DENY(RAM_DENY), .LIVE_PROTECT(LIVE_PROTECT), .LIVE_OPTION(LIVE_OPTION),
        .SECURED(SECURED), .LOAD_DONE(LOAD_DONE));
    fsol_nv_model #(.KEY(KEY), .PROT(8'h5a)) u_nv (.nv_addr(NV_ADDR), .nv_data(NV_DATA), .opt_byte(opt_byte));
    initial begin
        forever #10 MCLK = ~MCLK;
    end
    task chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            fail_count++;
        end
    endtask
    task expect_lock(input logic e);
        chk({7'h0, SECURED}, {7'h0, e});
    endtask
    task complete_run;
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge MCLK);
        #1;
        BUS_ADDR = a;
        BUS_WDATA = d;
        BUS_WR = 1;
        @(posedge MCLK);
        #1;
        BUS_WR = 0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge MCLK);
        #1;
        BUS_ADDR = a;
        BUS_RD = 1;
        @(posedge MCLK);
        #1;
        BUS_RD = 0;
        chk(BUS_RDATA, e);
    endtask
    // Key entry from the given source; flip spoils the compare
    task key(input logic dbg, input logic src, input logic [7:0] flip);
        BUS_DEBUG = dbg;
        BUS_FROM_SECURE = src;
        wr(16'h1823, 8'h20);
        for (int i = 0; i < 8; i++) wr(16'hffb0 + 16'(i), KEY[8*i +: 8] ^ flip);
        BUS_DEBUG = 0;
        BUS_FROM_SECURE = 1;
        repeat (3) @(posedge MCLK);
        #1;
    endtask
    task rst(input logic [7:0] o);
        int n;
        RESETN = 0;
        opt_byte = o;
        repeat (5) @(posedge MCLK);
        #1;
        chk(LIVE_OPTION, 8'h03);
        chk(LIVE_PROTECT, 8'hff);
        chk({7'h0, LOAD_DONE}, 8'h00);
        RESETN = 1;
        n = 0;
        while (LOAD_DONE !== 1'b1 && n < 20) begin
            @(posedge MCLK);
            #1;
            n++;
        end
        chk({7'h0, LOAD_DONE}, 8'h01);
        if (LOAD_DONE !== 1'b1) complete_run;
    endtask
    initial begin
        rst(8'hbf);
        chk(LIVE_OPTION, 8'h83);
        chk(LIVE_PROTECT, 8'h5a);
        rd(16'h1821, 8'h83);
        rd(16'h1822, 8'h00);
        wr(16'h1824, 8'h11);
        wr(16'h1824, 8'h22);
        rd(16'h1824, 8'h11);
        RAM_SEL = 1;
        BUS_DEBUG = 1;
        @(posedge MCLK);
        #1;
        chk({7'h0, RAM_DENY}, 8'h01);
        BUS_DEBUG = 0;
        BUS_FROM_SECURE = 0;
        @(posedge MCLK);
        #1;
        chk({7'h0, RAM_DENY}, 8'h01);
        BUS_FROM_SECURE = 1;
        key(1, 1, 8'h00);
        expect_lock(1);
        key(0, 0, 8'h00);
        expect_lock(1);
        key(0, 1, 8'h01);
        expect_lock(1);
        key(0, 1, 8'h00);
        expect_lock(0);
        rd(16'h1823, 8'h20);
        BUS_DEBUG = 1;
        @(posedge MCLK);
        #1;
        chk({7'h0, RAM_DENY}, 8'h00);
        BUS_DEBUG = 0;
        rst(8'h83);
        expect_lock(1);
        rst(8'h03);
        key(0, 1, 8'h00);
        expect_lock(1);
        BLANK_AFTER_ERASE = 1;
        @(posedge MCLK);
        #1;
        BLANK_AFTER_ERASE = 0;
        repeat (2) @(posedge MCLK);
        #1;
        expect_lock(0);
        for (int c = 0; c < 4; c++) begin
            rst(8'(c));
            expect_lock(c != 2);
        end
        complete_run;
    end
endmodule // flash_security_option_loader_tb_top
bind fsol_loader fsol_loader_props u_props (.MCLK(MCLK), .RESETN(RESETN), .BUS_ADDR(BUS_ADDR), .BUS_RD(BUS_RD),
    .BUS_DEBUG(BUS_DEBUG), .BUS_RDATA(BUS_RDATA), .BUS_HIT(BUS_HIT), .RAM_SEL(RAM_SEL), .RAM_DENY(RAM_DENY),
    .NV_ADDR(NV_ADDR), .LIVE_OPTION(LIVE_OPTION), .SECURED(SECURED), .LOAD_DONE(LOAD_DONE));
